// ### hdl/ctc_pkg.sv
// package for the cascadable 16-bit compare timer: register map, field layout,
// reset values, clock select codes, bus states and the block state carrier.
// assumes a 32-bit classic wishbone slave with 8-bit registers in the low byte lane.
`default_nettype none

package ctc_pkg;

  // byte addresses of the registers, one aligned word each
  localparam int unsigned ADR_W     = 6;
  localparam logic [5:0]  ADR_RUN   = 6'h00; // run control
  localparam logic [5:0]  ADR_LMOD  = 6'h04; // low mode
  localparam logic [5:0]  ADR_HMOD  = 6'h08; // high mode
  localparam logic [5:0]  ADR_LCYC  = 6'h0C; // low cycle compare
  localparam logic [5:0]  ADR_LDUTY = 6'h10; // low duty compare
  localparam logic [5:0]  ADR_HCYC  = 6'h14; // high cycle compare
  localparam logic [5:0]  ADR_SYS   = 6'h18; // system control
  localparam logic [5:0]  ADR_CNTL  = 6'h1C; // count, low byte (read only)
  localparam logic [5:0]  ADR_CNTH  = 6'h20; // count, high byte (read only)
  localparam logic [5:0]  ADR_STAT  = 6'h24; // pin and run state (read only)

  // bit positions in run control and system control
  localparam int unsigned RUN_LOW_BIT     = 0;
  localparam int unsigned RUN_HIGH_BIT    = 1;
  localparam int unsigned RUN_CAS_BIT     = 2;
  localparam int unsigned SYS_SLOWDIV_BIT = 0;
  localparam int unsigned SYS_LOWSPD_BIT  = 1;

  // mode register layout, msb first
  typedef struct packed {
    logic       dbe;      // double buffer enable
    logic [1:0] func;     // function select
    logic       ext;      // external clock select
    logic       init_lvl; // pulse pin idle level
    logic [2:0] clk_sel;  // source clock select
  } ctc_mode_t;

  localparam logic [1:0] FUNC_TMR_A = 2'h0; // timer
  localparam logic [1:0] FUNC_TMR_B = 2'h1; // timer, alternate code
  localparam logic [1:0] FUNC_PPG   = 2'h2; // pulse generator

  // reset values
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  CMP_RST  = 8'hFF;
  localparam logic [15:0] WCMP_RST = 16'hFFFF;

  // prescaler shift per select code, gear clock and sub clock
  localparam int unsigned PRE_W = 11;
  localparam int unsigned SUB_W = 4;
  localparam logic [3:0] GEAR_EXP [0:7] = '{4'hB, 4'hA, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1, 4'h0};
  localparam logic [2:0] CK_SUB_A = 3'h0; // sub clock / 16 in slow selections
  localparam logic [2:0] CK_SUB_B = 3'h1; // sub clock / 8
  localparam logic [2:0] CK_SUB_C = 3'h7; // sub clock / 4 in low-speed modes
  localparam logic [3:0] SUB_EXP_A = 4'h4;
  localparam logic [3:0] SUB_EXP_B = 4'h3;
  localparam logic [3:0] SUB_EXP_C = 4'h2;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    CTC_BUS_IDLE = 2'b01,
    CTC_BUS_ACK  = 2'b10
  } ctc_bus_t;

  // whole state of the block
  typedef struct packed {
    ctc_bus_t   bus;      // handshake state
    logic [7:0] rdat;     // read data
    logic [2:0] run;      // cascade, high run, low run
    ctc_mode_t  lmode;    // low mode
    ctc_mode_t  hmode;    // high mode
    logic [1:0] sys;      // low-speed, slow divider
    logic [7:0] lcyc_wr;  // last written low cycle byte
    logic [7:0] lduty_wr; // last written low duty byte
    logic [7:0] hcyc_wr;  // last written high cycle byte
    logic [7:0] lcyc_act; // active low cycle compare
    logic [7:0] ldty_act; // active low duty compare
    logic [15:0] hbuf;    // wide compare buffer
    logic [15:0] hact;    // active wide compare
    logic [15:0] cnt;     // up counter, low timer uses bits 7..0
    logic [PRE_W-1:0] pre;   // gear prescaler
    logic [SUB_W-1:0] sdiv;  // sub clock prescaler
    logic [2:0] ssync;    // sub clock synchroniser and edge stage
    logic       pin;      // pulse output
    logic       hirq;     // wide match pulse
    logic       lirq;     // low cycle match pulse
  } ctc_state_t;

endpackage : ctc_pkg

`default_nettype wire

// ### hdl/ctc_top.sv
// cascadable timer: two 8-bit timers that join into a 16-bit compare timer,
// plus the low timer's pulse generator, behind a classic wishbone slave.
// assumes the sub clock arrives asynchronously on a pin; the gear clock is clk_i.
`default_nettype none

module ctc_top (
  input  wire logic        clk_i,                  // gear clock, 50 MHz
  input  wire logic        rst_i,                  // synchronous reset, high
  input  wire logic        wb_cyc_i,               // bus cycle
  input  wire logic        wb_stb_i,               // bus strobe
  input  wire logic        wb_we_i,                // write enable
  input  wire logic [5:0]  wb_adr_i,               // byte address
  input  wire logic [3:0]  wb_sel_i,               // byte lanes
  input  wire logic [31:0] wb_dat_i,               // write data
  output logic      [31:0] wb_dat_o,               // read data
  output logic             wb_ack_o,               // acknowledge
  input  wire logic        sub_clk_i,              // slow sub clock pin
  output logic             pulse_output_pin_o,     // pulse generator output
  output logic             high_match_interrupt_o, // wide match, one cycle
  output logic             low_match_interrupt_o   // low cycle match, one cycle
);

  ctc_pkg::ctc_state_t q;  // registered state
  ctc_pkg::ctc_state_t d;  // next state
  // one struct holds every flop, so reset and update live in one place;
  // the cost is that unused fields ride along and are left to synthesis

  // gear prescaler tap: true once every 2^e clocks
  // the prescaler is never cleared, so the first period after a start may be short
  function automatic logic gear_tap(input logic [10:0] pre, input logic [3:0] e);
    logic [10:0] m;
    m = 11'((11'h1 << e) - 11'h1);
    return (pre & m) == m;
  endfunction : gear_tap

  // sub prescaler tap: true on every 2^e-th sub clock edge
  function automatic logic sub_tap(input logic edge_s, input logic [3:0] div,
                                   input logic [3:0] e);
    logic [3:0] m;
    m = 4'((4'h1 << e) - 4'h1);
    return edge_s && ((div & m) == m);
  endfunction : sub_tap

  // source clock enable for one select code
  // low-speed wins over the slow divider bit: only sub clock codes survive,
  // since the gear clock is taken to be stopped in those modes
  function automatic logic src_tick(input logic [2:0] sel, input logic slow_div,
                                    input logic low_spd, input logic [10:0] pre,
                                    input logic edge_s, input logic [3:0] div);
    logic t;
    t = 1'b0;
    if (low_spd) begin
      case (sel)
        ctc_pkg::CK_SUB_A: t = sub_tap(edge_s, div, ctc_pkg::SUB_EXP_A);
        ctc_pkg::CK_SUB_B: t = sub_tap(edge_s, div, ctc_pkg::SUB_EXP_B);
        ctc_pkg::CK_SUB_C: t = sub_tap(edge_s, div, ctc_pkg::SUB_EXP_C);
        default:           t = 1'b0;
      endcase
    end else if (slow_div && sel == ctc_pkg::CK_SUB_A) begin
      t = sub_tap(edge_s, div, ctc_pkg::SUB_EXP_A);
    end else if (slow_div && sel == ctc_pkg::CK_SUB_B) begin
      t = sub_tap(edge_s, div, ctc_pkg::SUB_EXP_B);
    end else begin
      t = gear_tap(pre, ctc_pkg::GEAR_EXP[sel]);
    end
    return t;
  endfunction : src_tick

  // decoded helpers, all from registered state or the bus
  // kept combinational so that the checks below can name them
  logic        sub_edge;  // rising sub clock edge, from synchronised stages
  logic        cas;       // timers joined
  logic        hi_run;    // wide counter running
  logic        lo_run;    // low pulse generator running
  logic        htick;     // wide source clock enable
  logic        ltick;     // low source clock enable
  logic        req;       // new bus request taken this edge
  logic        wr;        // write taken this edge
  logic [7:0]  wdat;      // write byte
  logic [15:0] wide_new;  // wide compare formed on high byte write
  logic [15:0] cnt_nxt;   // count plus one
  logic [7:0]  lcnt_nxt;  // low count plus one
  logic        wr_hcyc;   // high cycle write
  logic        wr_lcyc;   // low cycle write
  logic        wr_ldty;   // low duty write
  logic        hmatch;    // wide match this edge
  logic        lcyc_hit;  // low cycle match this edge
  logic        ldty_hit;  // low duty match this edge

  always_comb begin
    // only the second and third synchroniser stages are looked at
    sub_edge = q.ssync[1] & ~q.ssync[2];
    cas      = q.run[ctc_pkg::RUN_CAS_BIT];
    hi_run   = cas && q.run[ctc_pkg::RUN_HIGH_BIT] && !q.hmode.ext &&
               (q.hmode.func == ctc_pkg::FUNC_TMR_A || q.hmode.func == ctc_pkg::FUNC_TMR_B);
    lo_run   = !cas && q.run[ctc_pkg::RUN_LOW_BIT] && !q.lmode.ext &&
               q.lmode.func == ctc_pkg::FUNC_PPG;
    htick    = src_tick(q.hmode.clk_sel, q.sys[ctc_pkg::SYS_SLOWDIV_BIT],
                        q.sys[ctc_pkg::SYS_LOWSPD_BIT], q.pre, sub_edge, q.sdiv);
    ltick    = src_tick(q.lmode.clk_sel, q.sys[ctc_pkg::SYS_SLOWDIV_BIT],
                        q.sys[ctc_pkg::SYS_LOWSPD_BIT], q.pre, sub_edge, q.sdiv);
    req      = wb_cyc_i && wb_stb_i && q.bus == ctc_pkg::CTC_BUS_IDLE;
    wr       = req && wb_we_i && wb_sel_i[0];
    wdat     = wb_dat_i[7:0];
    wide_new = {wdat, q.lcyc_wr};
    cnt_nxt  = 16'(q.cnt + 16'h0001);
    lcnt_nxt = 8'(q.cnt[7:0] + 8'h01);
    wr_hcyc  = wr && wb_adr_i == ctc_pkg::ADR_HCYC;
    wr_lcyc  = wr && wb_adr_i == ctc_pkg::ADR_LCYC;
    wr_ldty  = wr && wb_adr_i == ctc_pkg::ADR_LDUTY;
    // a compare below the count never equals count+1 before the wrap, so the
    // lengthened interval after such a write needs no logic of its own
    // wide match: count step onto compare, or unbuffered write equal to count
    hmatch   = hi_run && ((htick && cnt_nxt == q.hact) ||
               (wr_hcyc && !q.hmode.dbe && wide_new == q.cnt));
    lcyc_hit = lo_run && ((ltick && lcnt_nxt == q.lcyc_act) ||
               (wr_lcyc && !q.lmode.dbe && wdat == q.cnt[7:0]));
    ldty_hit = lo_run && ((ltick && lcnt_nxt == q.ldty_act) ||
               (wr_ldty && !q.lmode.dbe && wdat == q.cnt[7:0]));
  end

  // next state
  always_comb begin
    d      = q;
    d.hirq = 1'b0;
    d.lirq = 1'b0;

    // clock sources: free gear prescaler, sub clock synchroniser and divider
    d.pre   = q.pre + 11'h001;
    d.ssync = {q.ssync[1:0], sub_clk_i};
    if (sub_edge) begin
      d.sdiv = q.sdiv + 4'h1;
    end

    // bus handshake: ack one cycle after a request, then drop
    d.bus = req ? ctc_pkg::CTC_BUS_ACK : ctc_pkg::CTC_BUS_IDLE;
    // a strobe left high after ack is taken again, so a master
    // must drop it once it has seen ack
    if (req) begin
      case (wb_adr_i)
        ctc_pkg::ADR_RUN:   d.rdat = {5'h00, q.run};
        ctc_pkg::ADR_LMOD:  d.rdat = q.lmode;
        ctc_pkg::ADR_HMOD:  d.rdat = q.hmode;
        ctc_pkg::ADR_LCYC:  d.rdat = q.lcyc_wr;
        ctc_pkg::ADR_LDUTY: d.rdat = q.lduty_wr;
        ctc_pkg::ADR_HCYC:  d.rdat = q.hcyc_wr;
        ctc_pkg::ADR_SYS:   d.rdat = {6'h00, q.sys};
        ctc_pkg::ADR_CNTL:  d.rdat = q.cnt[7:0];
        ctc_pkg::ADR_CNTH:  d.rdat = q.cnt[15:8];
        ctc_pkg::ADR_STAT:  d.rdat = {5'h00, hi_run, lo_run, q.pin};
        default:            d.rdat = 8'h00;  // unmapped reads as zero
      endcase
    end

    // register writes; unmapped writes are acked and dropped
    // compare bytes are always kept for readback; only the active
    // copy depends on run state and the double buffer bit
    if (wr) begin
      case (wb_adr_i)
        ctc_pkg::ADR_RUN: d.run = wdat[2:0];
        ctc_pkg::ADR_LMOD: begin
          // a running timer keeps its mode
          if (!q.run[ctc_pkg::RUN_LOW_BIT]) begin
            d.lmode = wdat;
          end
        end
        ctc_pkg::ADR_HMOD: begin
          if (!q.run[ctc_pkg::RUN_HIGH_BIT]) begin
            d.hmode = wdat;
          end
        end
        ctc_pkg::ADR_SYS: d.sys = wdat[1:0];
        ctc_pkg::ADR_LCYC: begin
          d.lcyc_wr = wdat;
          // joined timers only latch the low half for the wide write
          if (!cas && (!lo_run || !q.lmode.dbe)) begin
            d.lcyc_act = wdat;
          end
        end
        ctc_pkg::ADR_LDUTY: begin
          d.lduty_wr = wdat;
          if (!cas && (!lo_run || !q.lmode.dbe)) begin
            d.ldty_act = wdat;
          end
        end
        ctc_pkg::ADR_HCYC: begin
          d.hcyc_wr = wdat;
          d.hbuf    = wide_new;
          if (!hi_run || !q.hmode.dbe) begin
            d.hact = wide_new;
          end
        end
        default: ;
      endcase
    end

    // counters
    // a match has priority over the plain tick, so a step onto the
    // compare value clears the count instead of loading it
    if (hi_run) begin
      if (hmatch) begin
        d.cnt  = 16'h0000;
        d.hirq = 1'b1;
        if (q.hmode.dbe) begin
          d.hact = d.hbuf;
        end
      end else if (htick) begin
        d.cnt = cnt_nxt;
      end
      d.pin = q.lmode.init_lvl;
    end else if (lo_run) begin
      // duty and cycle match on one edge: the cycle match wins
      if (lcyc_hit) begin
        d.cnt  = 16'h0000;
        d.pin  = q.lmode.init_lvl;
        d.lirq = 1'b1;
        if (q.lmode.dbe) begin
          d.lcyc_act = d.lcyc_wr;
          d.ldty_act = d.lduty_wr;
        end
      end else begin
        if (ldty_hit) begin
          d.pin = ~q.lmode.init_lvl;
        end
        if (ltick) begin
          d.cnt = {8'h00, lcnt_nxt};
        end
      end
    end else begin
      // stopped: count cleared, pin at its idle level
      d.cnt = 16'h0000;
      d.pin = q.lmode.init_lvl;
    end
  end

  // state register
  // fields with a non-zero reset value, and the two mode registers, are named after the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.bus      <= ctc_pkg::CTC_BUS_IDLE;
      q.lmode    <= ctc_pkg::MODE_RST;
      q.hmode    <= ctc_pkg::MODE_RST;
      q.lcyc_wr  <= ctc_pkg::CMP_RST;
      q.lduty_wr <= ctc_pkg::CMP_RST;
      q.hcyc_wr  <= ctc_pkg::CMP_RST;
      q.lcyc_act <= ctc_pkg::CMP_RST;
      q.ldty_act <= ctc_pkg::CMP_RST;
      q.hbuf     <= ctc_pkg::WCMP_RST;
      q.hact     <= ctc_pkg::WCMP_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state flops
  // registers are one byte wide, so the upper read lanes are zero
  assign wb_dat_o               = {24'h000000, q.rdat};
  assign wb_ack_o               = q.bus[1];
  assign pulse_output_pin_o     = q.pin;
  assign high_match_interrupt_o = q.hirq;
  assign low_match_interrupt_o  = q.lirq;

  // checks
  // all on the gear clock, off while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wide_step;
    hi_run && htick && cnt_nxt == q.hact && !wr;
  endsequence

  sequence s_wide_wrap;
    hi_run && htick && q.cnt == 16'hFFFF && q.hact != 16'h0000 && !wr;
  endsequence

  a_wide_match_clr: assert property (s_wide_step |=> q.cnt == 16'h0000 && q.hirq)
    else $error("wide match did not clear count and raise interrupt");
  a_wide_wrap_quiet: assert property (s_wide_wrap |=> q.cnt == 16'h0000 && !q.hirq)
    else $error("wide wrap without match raised interrupt");
  a_stop_zeroes: assert property (!hi_run && !lo_run |=> q.cnt == 16'h0000)
    else $error("stopped counter not zero");
  a_hmode_locked: assert property (wr && wb_adr_i == ctc_pkg::ADR_HMOD &&
                                   q.run[ctc_pkg::RUN_HIGH_BIT] |=> $stable(q.hmode))
    else $error("high mode changed while running");
  a_buf_holds: assert property (wr_hcyc && hi_run && q.hmode.dbe && !hmatch
                                |=> q.hact == $past(q.hact) && q.hbuf == $past(wide_new))
    else $error("buffered write reached active compare early");
  a_direct_load: assert property (wr_hcyc && (!q.hmode.dbe || !hi_run) && !hmatch
                                  |=> q.hact == q.hbuf && q.hcyc_wr == q.hbuf[15:8])
    else $error("unbuffered write did not load active compare");
  a_equal_match: assert property (hi_run && wr_hcyc && !q.hmode.dbe &&
                                  wide_new == q.cnt |=> q.hirq && q.cnt == 16'h0000)
    else $error("equal compare write gave no immediate match");
  a_low_spd_none: assert property (q.sys[ctc_pkg::SYS_LOWSPD_BIT] &&
                                   q.hmode.clk_sel inside {[3'h2:3'h6]} |-> !htick)
    else $error("low-speed mode produced a forbidden source clock");
  a_cas_low_off: assert property (cas |=> !q.lirq)
    else $error("low timer interrupted while cascaded");
  a_duty_toggle: assert property (ldty_hit && !lcyc_hit |=> q.pin != q.lmode.init_lvl)
    else $error("duty match did not toggle pulse pin");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_follows: assert property (req |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");

  // stopped and buffered writes, readback of what software wrote, source clock rates
  a_buf_stopped: assert property (wr_hcyc && !hi_run && q.hmode.dbe
                                  |=> q.hact == $past(wide_new) && q.hbuf == q.hact)
    else $error("stopped buffered write did not load both registers");
  a_cmp_readback: assert property (wr_hcyc |=> q.hcyc_wr == $past(wdat))
    else $error("high compare readback lost the written byte");
  a_low_readback: assert property (wr_lcyc |=> q.lcyc_wr == $past(wdat))
    else $error("low compare readback lost the written byte");
  a_full_rate: assert property (hi_run && q.hmode.clk_sel == 3'h7 &&
                                q.sys == 2'h0 |-> htick)
    else $error("undivided clock select did not tick every cycle");
  a_low_spd_quiet: assert property (q.sys[ctc_pkg::SYS_LOWSPD_BIT] &&
                                    q.lmode.clk_sel inside {[3'h2:3'h6]} |-> !ltick)
    else $error("low-speed mode gave the low timer a forbidden clock");

  // low timer pulse generator; it shares the low byte of the counter
  sequence s_low_cycle;
    lo_run && lcyc_hit;
  endsequence

  a_low_cycle_clr: assert property (s_low_cycle |=> q.cnt == 16'h0000 && q.lirq)
    else $error("low cycle match did not clear count and raise interrupt");
  a_low_pin_back: assert property (s_low_cycle |=> q.pin == q.lmode.init_lvl)
    else $error("cycle match did not restore pulse pin");
  a_low_direct: assert property (wr_lcyc && !cas && (!lo_run || !q.lmode.dbe)
                                 |=> q.lcyc_act == $past(wdat))
    else $error("unbuffered low cycle write did not apply at once");
  a_low_buf_hold: assert property (wr_lcyc && lo_run && q.lmode.dbe && !lcyc_hit
                                   |=> q.lcyc_act == $past(q.lcyc_act))
    else $error("buffered low cycle write applied early");
  a_low_equal: assert property (wr_ldty && lo_run && !q.lmode.dbe && !lcyc_hit &&
                                wdat == q.cnt[7:0] |=> q.pin != q.lmode.init_lvl)
    else $error("duty write equal to count did not toggle pulse pin");
  a_cas_pin_idle: assert property (cas |=> q.pin == $past(q.lmode.init_lvl))
    else $error("pulse pin left its idle level while cascaded");

endmodule : ctc_top

`default_nettype wire

// ### test/ctc_top_bench.sv
// self-checking bench for the cascadable compare timer: drives the bus and sub clock.
// assumes one 50 MHz clock, 8-bit registers in the low lane and a one-cycle ack.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module ctc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i     = 1'b0;    // gear clock
  logic        rst_i     = 1'b1;    // synchronous reset
  logic        wb_cyc_i  = 1'b0;    // bus cycle
  logic        wb_stb_i  = 1'b0;    // bus strobe
  logic        wb_we_i   = 1'b0;    // write enable
  logic [5:0]  wb_adr_i  = 6'h00;   // address
  logic [3:0]  wb_sel_i  = 4'h0;    // lanes
  logic [31:0] wb_dat_i  = 32'h0;   // write data
  logic        sub_clk_i = 1'b0;    // slow clock pin
  logic [31:0] wb_dat_o;            // read data
  logic        wb_ack_o;            // acknowledge
  logic        pin_o;               // pulse output
  logic        hirq_o;              // wide match pulse
  logic        lirq_o;              // low match pulse
  int          mismatches  = 0;     // failed compares
  int          checks_done = 0;     // compares made
  int          cyc_n       = 0;     // free cycle count for intervals
  int          hcount      = 0;     // wide match pulses seen
  int          stray       = 0;     // low activity while cascaded
  logic        casc_chk    = 1'b0;  // watch low side in cascade

  ctc_top u_ctc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clk_i(sub_clk_i),
    .pulse_output_pin_o(pin_o), .high_match_interrupt_o(hirq_o), .low_match_interrupt_o(lirq_o));

  // clocks: sub clock period is ten gear cycles, edges fall between gear rising edges
  always #10ns clk_i = ~clk_i;
  always #100ns sub_clk_i = ~sub_clk_i;

  // monitors sampled on the gear clock
  always @(posedge clk_i) begin
    // non-blocking, so tasks sampling at the same edge see the old count
    cyc_n <= cyc_n + 1;
    if (hirq_o === 1'b1) hcount <= hcount + 1;
    if (casc_chk && (lirq_o !== 1'b0 || pin_o !== 1'b0)) stray++;
  end

  // one classic cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    `CHK("bus ack", 1'b1, wb_ack_o)
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK("register read", e, q)
  endtask : rd_chk

  // wide compare goes low byte then high byte
  task automatic wcmp(input logic [15:0] v);
    wr(ctc_pkg::ADR_LCYC, v[7:0]);
    wr(ctc_pkg::ADR_HCYC, v[15:8]);
  endtask : wcmp

  // wait for a match pulse within lim cycles, report the cycle it was seen
  task automatic wait_irq(input logic hi, input int lim, output int t, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < lim) begin
      @(posedge clk_i);
      n++;
      if ((hi ? hirq_o : lirq_o) === 1'b1) begin
        ok = 1'b1;
        t = cyc_n;
      end
    end
  endtask : wait_irq

  task automatic need_irq(input logic hi, output int t);
    logic ok;
    wait_irq(hi, 9000, t, ok);
    `CHK("match pulse", 1'b1, ok)
  endtask : need_irq

  // stop, program system control, high mode and compare while stopped, then start cascaded with low run set too
  task automatic wide_setup(input logic [7:0] sys, input logic [7:0] md, input logic [15:0] c);
    wr(ctc_pkg::ADR_RUN, 8'h04);
    wr(ctc_pkg::ADR_SYS, sys);
    wr(ctc_pkg::ADR_HMOD, md);
    wcmp(c);
    wr(ctc_pkg::ADR_RUN, 8'h07);
  endtask : wide_setup

  task automatic t_reset;
    rd_chk(ctc_pkg::ADR_LCYC, 8'hFF);
    rd_chk(ctc_pkg::ADR_HCYC, 8'hFF);
    rd_chk(ctc_pkg::ADR_HMOD, 8'h00);
    rd_chk(ctc_pkg::ADR_CNTL, 8'h00);
    rd_chk(6'h3C, 8'h00);
  endtask : t_reset

  // every gear code; the low side is set up as a pulse generator and must stay silent
  task automatic t_gear;
    int t0;
    int t1;
    wr(ctc_pkg::ADR_RUN, 8'h00);
    wr(ctc_pkg::ADR_LMOD, 8'h47);
    casc_chk = 1'b1;
    for (int s = 0; s < 8; s++) begin
      wide_setup(8'h00, 8'(s), 16'h0002);
      need_irq(1'b1, t0);
      need_irq(1'b1, t1);
      `CHK("gear interval", 2 << ctc_pkg::GEAR_EXP[s], t1 - t0)
    end
    casc_chk = 1'b0;
    `CHK("low side activity", 0, stray)
  endtask : t_gear

  // sub clock selections; zero means no source clock at all
  task automatic t_sub;
    int sx[7] = '{2, 2, 2, 2, 1, 1, 1};
    int cx[7] = '{7, 0, 1, 2, 0, 1, 6};
    int ex[7] = '{80, 320, 160, 0, 320, 160, 4};
    int t0;
    int t1;
    logic ok;
    for (int i = 0; i < 7; i++) begin
      wide_setup(8'(sx[i]), 8'(cx[i]), 16'h0002);
      wait_irq(1'b1, (ex[i] == 0) ? 1000 : 2 * ex[i] + 50, t0, ok);
      if (ex[i] == 0) `CHK("dead code pulse", 1'b0, ok)
      else begin
        need_irq(1'b1, t1);
        `CHK("sub interval", ex[i], t1 - t0)
      end
    end
    wr(ctc_pkg::ADR_SYS, 8'h00);
  endtask : t_sub

  task automatic t_buffered;
    int a;
    int b;
    int c;
    wide_setup(8'h00, 8'h87, 16'h0010);
    need_irq(1'b1, a);
    wcmp(16'h0008);
    need_irq(1'b1, b);
    need_irq(1'b1, c);
    `CHK("old compare kept", 16, b - a)
    `CHK("buffer applied", 8, c - b)
    rd_chk(ctc_pkg::ADR_LCYC, 8'h08);
    rd_chk(ctc_pkg::ADR_HCYC, 8'h00);
  endtask : t_buffered

  task automatic t_unbuffered;
    int a;
    int b;
    logic ok;
    wide_setup(8'h00, 8'h07, 16'h0040);
    need_irq(1'b1, a);
    wcmp(16'h0020);
    need_irq(1'b1, b);
    `CHK("direct compare", 32, b - a)
    wr(ctc_pkg::ADR_HMOD, 8'h80);
    rd_chk(ctc_pkg::ADR_HMOD, 8'h07);
    repeat (40) @(posedge clk_i);
    wcmp(16'h0010);
    wait_irq(1'b1, 600, a, ok);
    `CHK("below count pulse", 1'b0, ok)
    wr(ctc_pkg::ADR_RUN, 8'h04);
    rd_chk(ctc_pkg::ADR_CNTL, 8'h00);
    rd_chk(ctc_pkg::ADR_CNTH, 8'h00);
  endtask : t_unbuffered

  // slow code, so the count is stable while the equal value is written
  task automatic t_equal;
    logic [7:0] q;
    int n;
    int h0;
    q = 8'h00;
    n = 0;
    wide_setup(8'h00, 8'h00, 16'hFFFF);
    while (q === 8'h00 && n < 2000) begin
      wb(1'b0, ctc_pkg::ADR_CNTL, 8'h00, q);
      n++;
    end
    h0 = hcount;
    wcmp({8'h00, q});
    repeat (3) @(posedge clk_i);
    `CHK("equal write pulses", 1, hcount - h0)
    rd_chk(ctc_pkg::ADR_CNTL, 8'h00);
    wr(ctc_pkg::ADR_RUN, 8'h00);
  endtask : t_equal

  task automatic pin_period(input int ecyc, input int ehi);
    int n;
    int h;
    n = 0;
    h = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (pin_o === 1'b1) h++;
    end while (lirq_o !== 1'b1 && n < 100);
    `CHK("pulse period", ecyc, n)
    `CHK("pulse high time", ehi, h)
  endtask : pin_period

  task automatic t_pulse;
    int a;
    int b;
    int c;
    wr(ctc_pkg::ADR_LMOD, 8'h4F);
    @(posedge clk_i);
    `CHK("idle level", 1'b1, pin_o)
    wr(ctc_pkg::ADR_LMOD, 8'h47);
    wr(ctc_pkg::ADR_LCYC, 8'h08);
    wr(ctc_pkg::ADR_LDUTY, 8'h03);
    wr(ctc_pkg::ADR_RUN, 8'h01);
    need_irq(1'b0, a);
    pin_period(8, 5);
    need_irq(1'b0, a);
    wr(ctc_pkg::ADR_LCYC, 8'h10);
    need_irq(1'b0, b);
    `CHK("low direct write", 16, b - a)
    pin_period(16, 13);
    wr(ctc_pkg::ADR_RUN, 8'h00);
    wr(ctc_pkg::ADR_LMOD, 8'hC7);
    wr(ctc_pkg::ADR_LCYC, 8'h08);
    wr(ctc_pkg::ADR_RUN, 8'h01);
    need_irq(1'b0, a);
    wr(ctc_pkg::ADR_LCYC, 8'h04);
    need_irq(1'b0, b);
    need_irq(1'b0, c);
    `CHK("low old cycle", 8, b - a)
    `CHK("low new cycle", 4, c - b)
  endtask : t_pulse

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gear();
    t_sub();
    t_buffered();
    t_unbuffered();
    t_equal();
    t_pulse();
    finish_test();
  end

  // watchdog, well beyond the roughly 20k cycles the sequence needs
  initial begin
    #1600us;
    mismatches++;
    finish_test();
  end

endmodule : ctc_top_bench

`undef CHK
`default_nettype wire
